// ===== dv/rss_chk.sv
`timescale 1ns/100ps
`default_nettype none
module rss_chk
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic busy_o,
    input wire logic skip_o
);
    // ========
    // Timing
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Command taken by an idle block; a busy block drops it
    sequence s_cmd(logic [2:0] op);
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00 && wb_dat_i[2:0] == op && !busy_o;
    endsequence
    // One execute cycle, never a skip
    sequence s_one;
        busy_o && !skip_o ##1 !busy_o && !skip_o;
    endsequence
    // Execute, then a dummy cycle only when skipping
    sequence s_dec;
        busy_o && !skip_o ##1 skip_o == busy_o ##1 !busy_o;
    endsequence
    property p_rot; s_cmd(3'h0) |=> s_one; endproperty
    a_rot: assert property (p_rot) else $error("rotate timing wrong");
    property p_sbw; s_cmd(3'h1) |=> s_one; endproperty
    a_sbw: assert property (p_sbw) else $error("subtract timing wrong");
    property p_sbm; s_cmd(3'h2) |=> s_one; endproperty
    a_sbm: assert property (p_sbm) else $error("subtract to memory timing wrong");
    property p_dsm; s_cmd(3'h3) |=> s_dec; endproperty
    a_dsm: assert property (p_dsm) else $error("decrement skip timing wrong");
    property p_dsw; s_cmd(3'h4) |=> s_dec; endproperty
    a_dsw: assert property (p_dsw) else $error("decrement skip to wreg timing wrong");
    property p_skip; skip_o |-> $past(busy_o) && busy_o ##1 !busy_o && !skip_o; endproperty
    a_skip: assert property (p_skip) else $error("dummy cycle wrong");
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long");
endmodule : rss_chk
bind rotate_subtract_skip_datapath rss_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i,
    .wb_adr_i, .wb_dat_i, .wb_ack_o, .busy_o, .skip_o);
`default_nettype wire

// ===== dv/test_rotate_subtract_skip_datapath.sv
`timescale 1ns/100ps
`default_nettype none
module test_rotate_subtract_skip_datapath;
    // ========
    // Signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    rss_pkg::wb_req_s req = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic busy_o;
    logic skip_o;
    logic [31:0] exp_q[$];
    logic [7:0] cnt = 8'h00;
    logic [15:0] busy_n = 16'h0000;
    logic [7:0] skip_n = 8'h00;
    int fails = 0;
    int cmp_count = 0;
    int cyc_n = 0;

    rotate_subtract_skip_datapath DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
        .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .busy_o(busy_o), .skip_o(skip_o));

    // Clock, 10 ns period
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    // ========
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] e);
        cmp_count++;
        if (got !== e)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, e);
        end
    endtask : check

    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // Request held until ack is seen, then one idle cycle
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        req <= '{1'b1, 1'b1, we, sel, adr, dat};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        req <= '0;
        @(posedge clk_i);
    endtask : bus

    task automatic rd(input logic [7:0] adr, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, adr, 32'h0, 4'($urandom));
    endtask : rd

    // Load operands, run one op, read every result back
    task automatic run_op(input logic [2:0] op, input logic [3:0] idx, input logic [7:0] a, input logic [7:0] m,
        input logic [3:0] f);
        logic [7:0] ma;
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] d;
        logic [7:0] w;
        logic [3:0] fl;
        logic sk;
        ma = 8'h40 + {2'b00, idx, 2'b00};
        s = {1'b0, a} + {1'b0, ~m} + {8'h00, f[0]};
        h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, f[0]};
        d = m - 8'h01;
        sk = (op == 3'h3 || op == 3'h4) && (d == 8'h00);
        cnt += 8'(sk);
        w = (op == 3'h0) ? {f[0], m[7:1]} : (op == 3'h1) ? s[7:0] : (op == 3'h4) ? d : a;
        fl = (op == 3'h0) ? {f[3:1], m[0]} : f;
        if (op == 3'h1 || op == 3'h2)
            fl = {(a[7] != m[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
        bus(1'b1, 8'h04, {24'h0, a}, 4'hf);
        bus(1'b1, 8'h08, {28'h0, f}, 4'hf);
        bus(1'b1, ma, {24'h0, m}, 4'hf);
        bus(1'b1, 8'h00, {24'h0, idx, 1'b0, op}, 4'hf);
        repeat (3) @(posedge clk_i);
        rd(8'h00, {24'h0, idx, 1'b0, op});
        rd(8'h04, {24'h0, w});
        rd(ma, {24'h0, (op == 3'h2) ? s[7:0] : (op == 3'h3) ? d : m});
        rd(8'h08, {28'h0, fl});
        rd(8'h0c, {16'h0, cnt, 6'h0, sk, 1'b0});
        $display("op %0d done", op);
    endtask : run_op

    // Read data checked against the oldest note; a hang ends the run
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && req.we === 1'b0)
        begin
            if (exp_q.size() > 0)
                check(wb_dat_o, exp_q.pop_front());
            else
            begin
                fails++;
                $display("CHECK FAILED t=%0t read answered with no note", $time);
            end
        end
        busy_n += 16'(busy_o === 1'b1);
        skip_n += 8'(skip_o === 1'b1);
        cyc_n++;
        if (cyc_n == 5000)
        begin
            fails++;
            finish_test();
        end
    end

    // Main sequence: defaults, refused writes, then every op with zero and wrap cases
    initial
    begin
        void'($urandom(32'hc36e));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h7c, 32'h0);
        bus(1'b1, 8'h04, 32'h5a, 4'h0);
        rd(8'h04, 32'h0);
        bus(1'b1, 8'h20, 32'h5a, 4'hf);
        rd(8'h20, 32'h0);
        $display("reset and bus test done");
        // Codes 5 to 7 must run one idle execute cycle, clear the skip status bit and change nothing else
        for (int i = 0; i < 40; i++)
            run_op(3'(i % 8), 4'($urandom), 8'($urandom), (i >= 32) ? 8'h01 : (i >= 24) ? 8'h00 : 8'($urandom),
                4'($urandom));
        // One skip pulse per taken skip; busy for every execute plus every dummy cycle
        check({24'h0, skip_n}, {24'h0, cnt});
        check({16'h0, busy_n}, {16'h0, 16'h0028 + {8'h00, cnt}});
        finish_test();
    end
endmodule : test_rotate_subtract_skip_datapath
`default_nettype wire

// ===== pkg/rss_pkg.sv
`default_nettype none

package rss_pkg;

    // ==========================================
    // Register map (byte addresses, one word each)
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_WREG = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_MEM_BASE = 8'h40;
    localparam logic [7:0] ADDR_MEM_MASK = 8'hc0;

    // ==========================================
    // Field positions
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ADDR_LSB = 4;
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_HALF = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_OVF = 3;
    localparam int STAT_BUSY = 0;
    localparam int STAT_SKIP = 1;
    localparam int STAT_CNT_LSB = 8;

    // ==========================================
    // Sizes and reset values
    localparam int MEM_WORDS = 16;
    localparam int MEM_AW = 4;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [7:0] MEM_RST = 8'h00;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // Operation codes written to the command register
    typedef enum logic [2:0] {
        OP_ROTATE_RIGHT_CARRY_TO_WREG,
        OP_SUBTRACT_WITH_BORROW,
        OP_SUBTRACT_WITH_BORROW_TO_MEMORY,
        OP_DECREMENT_SKIP_ZERO,
        OP_DECREMENT_SKIP_ZERO_TO_WREG
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_DUMMY
    } state_e;

    // Status flags carried together
    typedef struct packed {
        logic overflow_flag;
        logic zero;
        logic half_carry_flag;
        logic carry;
    } flags_s;

    // Wishbone request bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_s;

endpackage : rss_pkg

`default_nettype wire

// ===== src/rotate_subtract_skip_datapath.sv
// Operation
// - The rotate-to-working-register op shifts {carry, memory byte} right by one and puts the low byte in wreg.
// - That rotate loads carry from memory bit 0 and puts the old carry into result bit 7.
// - That rotate leaves the memory byte untouched; only wreg and carry change.
// - Decrement-skip writes memory minus one back, and on a zero result discards the prefetch with a dummy cycle.
// - The to-wreg decrement-skip puts the value in wreg, keeps memory, and skips the same way.
`timescale 1ns/100ps
`default_nettype none

module rotate_subtract_skip_datapath
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Fetch pipeline side
    output logic busy_o,
    output logic skip_o
);

    // ==========================================
    // State
    typedef struct packed {
        rss_pkg::state_e state;
        rss_pkg::op_e op;
        logic [rss_pkg::MEM_AW-1:0] addr;
        logic [7:0] wreg;
        rss_pkg::flags_s flags;
        logic [rss_pkg::MEM_WORDS-1:0][7:0] mem;
        logic last_skip;
        logic [7:0] dummy_cnt;
        logic ack;
        logic [31:0] rdata;
        logic skip;
        logic busy;
    } state_s;

    state_s cur_ff;
    state_s nxt_cur;
    rss_pkg::wb_req_s req;

    // Decode a word address against one register offset
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] offs);
        hit = (adr[7:2] == offs[7:2]);
    endfunction : hit

    // Subtract with borrow: a + ~m + c, returning {ovf, half, carry, result}
    function automatic logic [10:0] sub_borrow(input logic [7:0] a, input logic [7:0] m, input logic c);
        logic [8:0] full;
        logic [4:0] low;
        logic ovf;
        full = {1'b0, a} + {1'b0, ~m} + {8'h00, c};
        low = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + {4'h0, c};
        ovf = (a[7] != m[7]) && (full[7] != a[7]);
        sub_borrow = {ovf, low[4], full[8], full[7:0]};
    endfunction : sub_borrow

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

    // ==========================================
    // Next-state logic
    always_comb
    begin
        logic access;
        logic commit;
        logic [7:0] opnd;
        logic [7:0] dec;
        logic [10:0] sb;
        logic [31:0] rd;
        access = 1'b0;
        commit = 1'b0;
        opnd = 8'h00;
        dec = 8'h00;
        sb = 11'h000;
        rd = rss_pkg::UNMAPPED_DATA;
        nxt_cur = cur_ff;
        nxt_cur.skip = 1'b0;

        // Bus: ack one cycle after the request, commit at the edge that sees ack
        access = req.cyc && req.stb;
        nxt_cur.ack = access && !cur_ff.ack;
        commit = access && cur_ff.ack && req.we && req.sel[0];
        if (hit(req.adr, rss_pkg::ADDR_CMD))
        begin
            rd = {24'h000000, cur_ff.addr, 1'b0, cur_ff.op};
        end
        else if (hit(req.adr, rss_pkg::ADDR_WREG))
        begin
            rd = {24'h000000, cur_ff.wreg};
        end
        else if (hit(req.adr, rss_pkg::ADDR_FLAGS))
        begin
            rd = {28'h0000000, cur_ff.flags};
        end
        else if (hit(req.adr, rss_pkg::ADDR_STAT))
        begin
            rd = {16'h0000, cur_ff.dummy_cnt, 6'h00, cur_ff.last_skip, cur_ff.state != rss_pkg::ST_IDLE};
        end
        else if ((req.adr & rss_pkg::ADDR_MEM_MASK) == rss_pkg::ADDR_MEM_BASE)
        begin
            rd = {24'h000000, cur_ff.mem[req.adr[rss_pkg::MEM_AW+1:2]]};
        end
        if (nxt_cur.ack)
        begin
            nxt_cur.rdata = rd;
        end

        // Register writes are refused while an operation runs
        if (commit && cur_ff.state == rss_pkg::ST_IDLE)
        begin
            if (hit(req.adr, rss_pkg::ADDR_CMD))
            begin
                nxt_cur.op = rss_pkg::op_e'(req.dat[rss_pkg::CMD_OP_LSB +: 3]);
                nxt_cur.addr = req.dat[rss_pkg::CMD_ADDR_LSB +: rss_pkg::MEM_AW];
                nxt_cur.state = rss_pkg::ST_EXEC;
            end
            else if (hit(req.adr, rss_pkg::ADDR_WREG))
            begin
                nxt_cur.wreg = req.dat[7:0];
            end
            else if (hit(req.adr, rss_pkg::ADDR_FLAGS))
            begin
                nxt_cur.flags = req.dat[3:0];
            end
            else if ((req.adr & rss_pkg::ADDR_MEM_MASK) == rss_pkg::ADDR_MEM_BASE)
            begin
                nxt_cur.mem[req.adr[rss_pkg::MEM_AW+1:2]] = req.dat[7:0];
            end
        end

        // Execution: one cycle, plus one dummy cycle when a skip is taken
        opnd = cur_ff.mem[cur_ff.addr];
        dec = opnd - 8'h01;
        sb = sub_borrow(cur_ff.wreg, opnd, cur_ff.flags.carry);
        case (cur_ff.state)
            rss_pkg::ST_IDLE:
            begin
                nxt_cur.state = nxt_cur.state;
            end
            rss_pkg::ST_EXEC:
            begin
                nxt_cur.state = rss_pkg::ST_IDLE;
                nxt_cur.last_skip = 1'b0;
                case (cur_ff.op)
                    rss_pkg::OP_ROTATE_RIGHT_CARRY_TO_WREG:
                    begin
                        // Memory is never written here, so the operand survives
                        nxt_cur.wreg = {cur_ff.flags.carry, opnd[7:1]};
                        nxt_cur.flags.carry = opnd[0];
                    end
                    rss_pkg::OP_SUBTRACT_WITH_BORROW, rss_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEMORY:
                    begin
                        if (cur_ff.op == rss_pkg::OP_SUBTRACT_WITH_BORROW)
                        begin
                            nxt_cur.wreg = sb[7:0];
                        end
                        else
                        begin
                            nxt_cur.mem[cur_ff.addr] = sb[7:0];
                        end
                        nxt_cur.flags.carry = sb[8];
                        nxt_cur.flags.half_carry_flag = sb[9];
                        nxt_cur.flags.overflow_flag = sb[10];
                        nxt_cur.flags.zero = (sb[7:0] == 8'h00);
                    end
                    rss_pkg::OP_DECREMENT_SKIP_ZERO, rss_pkg::OP_DECREMENT_SKIP_ZERO_TO_WREG:
                    begin
                        // Flags deliberately left alone for both variants
                        if (cur_ff.op == rss_pkg::OP_DECREMENT_SKIP_ZERO)
                        begin
                            nxt_cur.mem[cur_ff.addr] = dec;
                        end
                        else
                        begin
                            nxt_cur.wreg = dec;
                        end
                        if (dec == 8'h00)
                        begin
                            nxt_cur.state = rss_pkg::ST_DUMMY;
                            nxt_cur.skip = 1'b1;
                            nxt_cur.last_skip = 1'b1;
                        end
                    end
                    default:
                    begin
                        nxt_cur.state = rss_pkg::ST_IDLE;
                    end
                endcase
            end
            rss_pkg::ST_DUMMY:
            begin
                // Dummy cycle stands in for the discarded prefetch
                nxt_cur.dummy_cnt = cur_ff.dummy_cnt + 8'h01;
                nxt_cur.state = rss_pkg::ST_IDLE;
            end
            default:
            begin
                nxt_cur.state = rss_pkg::ST_IDLE;
            end
        endcase

        // Busy is registered so the pin never glitches on a state decode
        nxt_cur.busy = (nxt_cur.state != rss_pkg::ST_IDLE);
    end

    // ==========================================
    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cur_ff <= '0;
            cur_ff.state <= rss_pkg::ST_IDLE;
            cur_ff.wreg <= rss_pkg::WREG_RST;
            cur_ff.flags <= rss_pkg::FLAGS_RST;
            cur_ff.mem <= {rss_pkg::MEM_WORDS{rss_pkg::MEM_RST}};
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs straight from flops; busy covers exec and dummy cycles
    assign wb_ack_o = cur_ff.ack;
    assign wb_dat_o = cur_ff.rdata;
    assign skip_o = cur_ff.skip;
    assign busy_o = cur_ff.busy;

endmodule : rotate_subtract_skip_datapath

`default_nettype wire
